// ### sst_pkg.sv
// ==========================================================================
// shared constants and types for the segment select and table loader
// ==========================================================================
package sst_pkg;

  // ========================================================================
  // register map (byte addresses, one word each)
  // ========================================================================
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_SELECT = 8'h04;
  localparam logic [7:0]  OFF_TABLE  = 8'h08;
  localparam logic [7:0]  OFF_STATUS = 8'h0c;
  localparam logic [7:0]  OFF_COUNT  = 8'h10;
  localparam logic [7:0]  OFF_BYTES  = 8'h14;

  // ========================================================================
  // field positions
  // ========================================================================
  localparam int CTRL_SRC_BIT  = 0;
  localparam int CTRL_TIM_BIT  = 1;
  localparam int CTRL_CH_LSB   = 4;
  localparam int TBL_EOI_BIT   = 8;
  localparam int STAT_LOAD_BIT = 16;
  localparam int STAT_PEND_BIT = 17;
  localparam int STAT_LOOK_BIT = 18;

  // ========================================================================
  // widths and codes
  // ========================================================================
  localparam int         SEG_W           = 16;
  localparam int         LEN_W           = 32;
  localparam int         EXT_CODE_W      = 8;
  localparam int         BYTES_PER_ENTRY = 4;
  localparam logic [7:0] ASCII_HASH      = 8'h23;
  localparam logic [7:0] ASCII_ZERO      = 8'h30;
  localparam logic [7:0] ASCII_NINE      = 8'h39;
  localparam logic [3:0] DEC_TEN         = 4'ha;

  // ========================================================================
  // modes and states
  // ========================================================================
  typedef enum logic {SRC_BUS = 1'b0, SRC_EXT = 1'b1} sst_src_t;
  typedef enum logic {TIM_COH = 1'b0, TIM_IMM = 1'b1} sst_tim_t;

  // loader walks the block header along a gray path
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_NDIG = 2'b01,
    LD_CNT  = 2'b11,
    LD_DATA = 2'b10
  } sst_ld_state_t;

  // one table entry: start address and length in points
  typedef struct packed {
    logic [LEN_W-1:0] start;
    logic [LEN_W-1:0] len;
  } sst_entry_t;

  // what the playback engine is told to play
  typedef struct packed {
    logic [SEG_W-1:0] seg;
    sst_entry_t       ent;
  } sst_play_t;

  localparam int ENTRY_W = $bits(sst_entry_t);

endpackage

// ### sst_mem.sv
`timescale 1ns/1ps
// ==========================================================================
// segment table memory: one write port, one read port, registered read
// ==========================================================================
module sst_mem #(
  parameter int W  = 64,
  parameter int AW = 15
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem_q [2**AW];

  // array write, no reset on the storage itself
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // read data always comes out of a register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule

// ### sst_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) bus source: only host select switches segment
// (RULE2) external source: 8-bit code plus validation line
// (RULE3) external code picks one of 256 segments
// (RULE4) coherent: switch waits for segment end point
// (RULE5) immediate: abort and switch at once
// (RULE6) timing mode applies to both sources
// (RULE7) source readable; bus after reset
// (RULE8) timing readable; coherent after reset
// (RULE9) host frames block: hash, digit count, digits
// (RULE10) host sends four bytes per entry
// (RULE11) block ends on eoi; cr/lf are data
// (RULE12) entries give lengths; starts chain back to back
// (RULE13) table load erases all, numbers from one
// (RULE14) one table buffer per channel, selected channel
// (RULE15) host sends 1 to 16000 entries
// (RULE16) host keeps segments at most 16M points
// (RULE17) no content checking, bad data just stored
// (RULE18) table load never touches waveform memory
// (RULE19) host pads later segments with 32 samples
// (RULE20) host keeps lengths >=192, multiple of 16
// (RULE21) sample code while valid high, new request
module sst_top
  import sst_pkg::*;
#(
  parameter int NUM_CH  = 2,
  parameter int MAX_SEG = 16000
) (
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  input  wire logic [EXT_CODE_W-1:0] ext_code_i,
  input  wire logic                  ext_valid_i,
  input  wire logic                  seg_end_i,
  output sst_play_t                  play_o,
  output logic                       play_load_o
);

  // ========================================================================
  // derived sizes
  // ========================================================================
  localparam int CH_W  = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int IDX_W = $clog2(MAX_SEG);
  localparam int CNT_W = $clog2(MAX_SEG + 1);
  localparam int AW    = CH_W + IDX_W;
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(MAX_SEG);

  // ========================================================================
  // declarations
  // ========================================================================
  sst_src_t            src_q;
  sst_tim_t            tim_q;
  logic [CH_W-1:0]     ch_q;
  logic [CNT_W-1:0]    cnt_q [NUM_CH];
  sst_ld_state_t       ld_state_q;
  logic [CH_W-1:0]     ld_ch_q;
  logic [3:0]          ndig_q;
  logic [31:0]         bytes_q;
  logic [1:0]          bidx_q;
  logic [23:0]         wacc_q;
  logic [LEN_W-1:0]    next_start_q;
  logic                mem_we;
  logic [AW-1:0]       mem_waddr;
  sst_entry_t          mem_wdata;
  sst_entry_t          mem_rdata;
  logic [AW-1:0]       mem_raddr;
  logic [7:0]          tb_byte;
  logic                tb_eoi;
  logic                tb_wr;
  logic [3:0]          digit;
  logic                is_digit;
  logic [EXT_CODE_W-1:0] code_s1_q;
  logic [EXT_CODE_W-1:0] code_s2_q;
  logic                val_s1_q;
  logic                val_s2_q;
  logic                val_d_q;
  logic                req;
  logic [SEG_W-1:0]    req_seg;
  logic                req_ok;
  logic                look_q;
  logic                look2_q;
  logic [SEG_W-1:0]    look_seg_q;
  logic [SEG_W-1:0]    look2_seg_q;
  logic                pend_q;
  sst_play_t           pend_data_q;
  logic                apply;

  // ========================================================================
  // register bus: control fields
  // ========================================================================
  // source, timing and channel choice, all software written
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_q <= SRC_BUS;                                   // [RULE7]
      tim_q <= TIM_COH;                                   // [RULE8]
      ch_q  <= '0;
    end else if (wr_i && addr_i == OFF_CTRL) begin
      src_q <= sst_src_t'(wdata_i[CTRL_SRC_BIT]);
      tim_q <= sst_tim_t'(wdata_i[CTRL_TIM_BIT]);
      // channels that do not exist are ignored
      if (32'(wdata_i[CTRL_CH_LSB +: CH_W]) < 32'(NUM_CH)) begin
        ch_q <= wdata_i[CTRL_CH_LSB +: CH_W];             // [RULE14]
      end
    end
  end

  // read data stand in the cycle after the read strobe only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        case (addr_i)
          OFF_CTRL: begin
            rdata_o[CTRL_SRC_BIT]         <= src_q;       // [RULE7]
            rdata_o[CTRL_TIM_BIT]         <= tim_q;       // [RULE8]
            rdata_o[CTRL_CH_LSB +: CH_W]  <= ch_q;
          end
          OFF_STATUS: begin
            rdata_o[SEG_W-1:0]    <= play_o.seg;
            rdata_o[STAT_LOAD_BIT] <= (ld_state_q != LD_IDLE);
            rdata_o[STAT_PEND_BIT] <= pend_q;
            rdata_o[STAT_LOOK_BIT] <= look_q | look2_q;
          end
          OFF_COUNT: begin
            rdata_o[CNT_W-1:0] <= cnt_q[ch_q];
          end
          OFF_BYTES: begin
            rdata_o <= bytes_q;
          end
          default: begin
            rdata_o <= '0;                                // unmapped: zero
          end
        endcase
      end
    end
  end

  // ========================================================================
  // table byte stream decode
  // ========================================================================
  // each write to the table register carries one byte and its eoi flag
  assign tb_wr    = wr_i && (addr_i == OFF_TABLE);
  assign tb_byte  = wdata_i[7:0];
  assign tb_eoi   = wdata_i[TBL_EOI_BIT];
  assign digit    = 4'(tb_byte - ASCII_ZERO);
  assign is_digit = (tb_byte >= ASCII_ZERO) && (tb_byte <= ASCII_NINE);

  // ========================================================================
  // table loader state machine
  // ========================================================================
  // header parse, then bytes gathered into 32-bit lengths
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ld_state_q <= LD_IDLE;
      ld_ch_q    <= '0;
      ndig_q     <= '0;
      bytes_q    <= '0;
    end else if (tb_wr) begin
      case (ld_state_q)
        LD_IDLE: begin
          if (tb_byte == ASCII_HASH && !tb_eoi) begin      // [RULE9]
            ld_state_q <= LD_NDIG;
            ld_ch_q    <= ch_q;                          // [RULE14]
            bytes_q    <= '0;
          end
        end
        LD_NDIG: begin
          // a zero digit count or a stray byte drops the block
          if (tb_eoi || !is_digit || digit == '0) begin
            ld_state_q <= LD_IDLE;
          end else begin
            ndig_q     <= digit;
            ld_state_q <= LD_CNT;
          end
        end
        LD_CNT: begin
          if (tb_eoi) begin
            ld_state_q <= LD_IDLE;
          end else begin
            // count kept for software only, never enforced
            bytes_q <= 32'(bytes_q * DEC_TEN) + 32'(digit); // [RULE17]
            ndig_q  <= ndig_q - 4'h1;
            if (ndig_q == 4'h1) begin
              ld_state_q <= LD_DATA;
            end
          end
        end
        LD_DATA: begin
          // only eoi ends the block; cr and lf are plain data
          if (tb_eoi) begin
            ld_state_q <= LD_IDLE;                         // [RULE11]
          end
        end
        default: begin
          ld_state_q <= LD_IDLE;
        end
      endcase
    end
  end

  // little-endian gathering of four bytes into one length
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bidx_q <= '0;
      wacc_q <= '0;
    end else if (tb_wr) begin
      if (ld_state_q == LD_DATA) begin
        wacc_q <= {tb_byte, wacc_q[23:8]};
        bidx_q <= bidx_q + 2'h1;                          // [RULE10]
        // a partial word at eoi is simply dropped
        if (tb_eoi) begin
          bidx_q <= '0;
        end
      end else begin
        bidx_q <= '0;
      end
    end
  end

  // entry write strobe on the fourth byte of a word
  assign mem_we = tb_wr && (ld_state_q == LD_DATA) &&
                  (bidx_q == 2'(BYTES_PER_ENTRY - 1)) &&
                  (cnt_q[ld_ch_q] < CNT_MAX);
  assign mem_wdata.len   = {tb_byte, wacc_q};             // [RULE12]
  assign mem_wdata.start = next_start_q;                  // [RULE12]
  assign mem_waddr = {ld_ch_q, IDX_W'(cnt_q[ld_ch_q])};

  // next start address follows the end of the previous segment
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      next_start_q <= '0;
    end else if (tb_wr && ld_state_q == LD_IDLE && tb_byte == ASCII_HASH) begin
      next_start_q <= '0;                                 // [RULE13]
    end else if (mem_we) begin
      next_start_q <= next_start_q + mem_wdata.len;       // [RULE12]
    end
  end

  // per-channel entry counts; a new block empties the channel table
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cnt_q[i] <= '0;
      end
    end else if (tb_wr && ld_state_q == LD_IDLE &&
                 tb_byte == ASCII_HASH && !tb_eoi) begin
      cnt_q[ch_q] <= '0;                                  // [RULE13]
    end else if (mem_we) begin
      cnt_q[ld_ch_q] <= cnt_q[ld_ch_q] + CNT_W'(1);       // [RULE13]
    end
  end

  // ========================================================================
  // segment table storage
  // ========================================================================
  // only the table is written here, waveform samples live elsewhere
  sst_mem #(
    .W  (ENTRY_W),
    .AW (AW)
  ) u_mem (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .we_i     (mem_we),                                   // [RULE18]
    .waddr_i  (mem_waddr),
    .wdata_i  (mem_wdata),
    .raddr_i  (mem_raddr),
    .rdata_o  (mem_rdata)
  );

  // ========================================================================
  // external select port synchroniser
  // ========================================================================
  // two flops on code and validation before any logic looks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_s1_q <= '0;
      code_s2_q <= '0;
      val_s1_q  <= 1'b0;
      val_s2_q  <= 1'b0;
      val_d_q   <= 1'b0;
    end else begin
      code_s1_q <= ext_code_i;
      code_s2_q <= code_s1_q;
      val_s1_q  <= ext_valid_i;
      val_s2_q  <= val_s1_q;
      val_d_q   <= val_s2_q;
    end
  end

  // ========================================================================
  // request source selection
  // ========================================================================
  // the inactive source is ignored entirely
  always_comb begin
    req     = 1'b0;
    req_seg = '0;
    if (src_q == SRC_BUS) begin
      req     = wr_i && (addr_i == OFF_SELECT);           // [RULE1]
      req_seg = wdata_i[SEG_W-1:0];
    end else begin
      // a fresh validation level samples the code once
      req     = val_s2_q && !val_d_q;                     // [RULE21]
      req_seg = SEG_W'(code_s2_q) + SEG_W'(1);            // [RULE2] [RULE3]
    end
  end

  // segment must exist in the current channel table
  assign req_ok = req && (req_seg != '0) &&
                  (req_seg <= SEG_W'(cnt_q[ch_q]));

  // ========================================================================
  // table lookup pipeline
  // ========================================================================
  assign mem_raddr = {ch_q, IDX_W'(look_seg_q - SEG_W'(1))};

  // two cycles: address held, then registered read data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      look_q      <= 1'b0;
      look2_q     <= 1'b0;
      look_seg_q  <= '0;
      look2_seg_q <= '0;
    end else begin
      look_q      <= req_ok;
      look2_q     <= look_q;
      look2_seg_q <= look_seg_q;
      if (req_ok) begin
        look_seg_q <= req_seg;
      end
    end
  end

  // ========================================================================
  // pending switch and transition timing
  // ========================================================================
  // coherent waits for the end point, immediate goes now
  assign apply = pend_q && ((tim_q == TIM_IMM) || seg_end_i); // [RULE6]

  // a newer lookup replaces any request still waiting
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q      <= 1'b0;
      pend_data_q <= '0;
    end else if (look2_q) begin
      pend_q          <= 1'b1;
      pend_data_q.seg <= look2_seg_q;
      pend_data_q.ent <= mem_rdata;
    end else if (apply) begin
      pend_q <= 1'b0;
    end
  end

  // playback outputs and one-cycle load pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      play_o      <= '0;
      play_load_o <= 1'b0;
    end else begin
      play_load_o <= 1'b0;
      if (apply && tim_q == TIM_IMM) begin
        play_o      <= pend_data_q;                       // [RULE5]
        play_load_o <= 1'b1;
      end else if (apply) begin
        play_o      <= pend_data_q;                       // [RULE4]
        play_load_o <= 1'b1;
      end
    end
  end

endmodule

// ### sst_top_chk.sv
`timescale 1ns/1ps
// ====================
// checker at the ports of the segment loader
module sst_top_chk
  import sst_pkg::*;
#(
  parameter int NUM_CH  = 2,
  parameter int MAX_SEG = 16000
) (
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic [31:0]           rdata_o,
  input  wire logic [EXT_CODE_W-1:0] ext_code_i,
  input  wire logic                  ext_valid_i,
  input  wire logic                  seg_end_i,
  input  wire sst_play_t             play_o,
  input  wire logic                  play_load_o
);
  logic       src_q;
  logic       tim_q;
  logic       vld_q;
  logic [3:0] age_q;

  // mirror of the source and timing bits
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_q <= 1'b0;
      tim_q <= 1'b0;
    end else if (wr_i && addr_i == OFF_CTRL) begin
      src_q <= wdata_i[CTRL_SRC_BIT];
      tim_q <= wdata_i[CTRL_TIM_BIT];
    end
  end

  // cycles since the validation line last rose
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vld_q <= 1'b0;
      age_q <= 4'hf;
    end else begin
      vld_q <= ext_valid_i;
      if (ext_valid_i && !vld_q) age_q <= 4'h0;
      else if (age_q != 4'hf) age_q <= age_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_rd_ctrl;
    rd_i && addr_i == OFF_CTRL;
  endsequence
  sequence s_bus_imm_load;
    play_load_o && src_q == SRC_BUS && tim_q == TIM_IMM;
  endsequence
  sequence s_ext_imm_load;
    play_load_o && src_q == SRC_EXT && tim_q == TIM_IMM;
  endsequence

  // ====================
  // assertions
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  AST_RD_MODE: assert property (
    s_rd_ctrl |=> rdata_o[1:0] == {tim_q, src_q})
    else $error("source or timing readback wrong");
  AST_COH_WAIT: assert property (
    tim_q == TIM_COH && !seg_end_i |=> !play_load_o)
    else $error("coherent switch without segment end");
  AST_BUS_IMM: assert property (
    s_bus_imm_load |-> $past(wr_i && addr_i == OFF_SELECT, 4))
    else $error("host switch not four cycles after select");
  AST_EXT_IMM: assert property (
    s_ext_imm_load |-> age_q inside {[3:10]})
    else $error("external switch not tied to validation");
  AST_PLAY_HOLD: assert property (!$stable(play_o) |-> play_load_o)
    else $error("play value moved without a load");
  AST_SEG_NZ: assert property (play_load_o |-> play_o.seg != 16'h0)
    else $error("segment zero loaded");
  AST_EXT_MAX: assert property (
    play_load_o && src_q == SRC_EXT |-> play_o.seg <= 16'h100)
    else $error("external segment beyond list");
endmodule

bind sst_top sst_top_chk #(.NUM_CH(NUM_CH), .MAX_SEG(MAX_SEG)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .ext_code_i(ext_code_i), .ext_valid_i(ext_valid_i),
  .seg_end_i(seg_end_i), .play_o(play_o), .play_load_o(play_load_o));

// ### sst_far_model.sv
`timescale 1ns/1ps
// ====================
// external select port and playback engine stand-in
module sst_far_model (
  input  wire logic       clk_i,
  output logic      [7:0] ext_code_o,
  output logic            ext_valid_o,
  output logic            seg_end_o
);
  // idle lines at time zero
  initial begin
    ext_code_o  = 8'h5a;
    ext_valid_o = 1'b0;
    seg_end_o   = 1'b0;
  end

  // code and validation move together; code turns over on release
  task automatic ext_sel(input logic [7:0] c);
    @(posedge clk_i);
    ext_code_o  <= c;
    ext_valid_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    ext_valid_o <= 1'b0;
    ext_code_o  <= ~c; // released lines do not hold the code
  endtask

  // engine reports the final point for one cycle
  task automatic end_seg();
    @(posedge clk_i);
    seg_end_o <= 1'b1;
    @(posedge clk_i);
    seg_end_o <= 1'b0;
  endtask
endmodule

// ### test_sst_top.sv
`timescale 1ns/1ps
// ====================
// self-checking bench for the segment loader
module test_sst_top
  import sst_pkg::*;
;
  logic              clk_i;
  logic              arst_n_i;
  logic [ADDR_W-1:0] addr_i;
  logic [31:0]       wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [31:0]       rdata_o;
  logic [7:0]        ext_code_i;
  logic              ext_valid_i;
  logic              seg_end_i;
  sst_play_t         play_o;
  logic              play_load_o;
  logic [31:0]       rd_q;
  int                fail_count;
  int                n_tests;

  sst_top #(.NUM_CH(2), .MAX_SEG(16)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_code_i(ext_code_i), .ext_valid_i(ext_valid_i),
    .seg_end_i(seg_end_i), .play_o(play_o), .play_load_o(play_load_o));
  sst_far_model far (.clk_i(clk_i), .ext_code_o(ext_code_i),
    .ext_valid_o(ext_valid_i), .seg_end_o(seg_end_i));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ====================
  // compares and bus cycles
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_play(input sst_play_t got, input sst_play_t exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_q = rdata_o;
    chk_word(rd_q, exp);
  endtask

  // header with two count digits, entries little-endian, eoi on last
  task automatic send_tbl(input logic [31:0] q[$]);
    int nb;
    nb = 4 * q.size();
    wr(OFF_TABLE, {24'h0, ASCII_HASH});
    wr(OFF_TABLE, {24'h0, ASCII_ZERO + 8'h2});
    wr(OFF_TABLE, {24'h0, 8'(ASCII_ZERO + nb / 10)});
    wr(OFF_TABLE, {24'h0, 8'(ASCII_ZERO + nb % 10)});
    for (int i = 0; i < nb; i++)
      wr(OFF_TABLE, {23'h0, i == nb - 1, q[i / 4][8 * (i % 4) +: 8]});
  endtask

  // load pulse may already stand when the task is called
  task automatic exp_load(input int n, input logic [15:0] s,
                          input logic [31:0] st, input logic [31:0] ln);
    for (int k = 0; k <= n; k++) begin
      #1;
      if (play_load_o === 1'b1) break;
      if (k < n) @(posedge clk_i);
    end
    chk_word({31'h0, play_load_o}, 32'h1);
    chk_play(play_o, {s, st, ln});
  endtask

  task automatic no_load(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (play_load_o !== 1'b0) seen = 1'b1;
    end
    chk_word({31'h0, seen}, 32'h0);
  endtask

  // ====================
  // main sequence
  initial begin
    arst_n_i = 1'b0;
    addr_i   = '0;
    wdata_i  = '0;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    fail_count = 0;
    n_tests    = 0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_COUNT, 32'h0);
    // entry bytes hold cr and lf; later lengths carry 32 pad points
    send_tbl('{32'h0d00, 32'h0a20, 32'h0c20});
    rd_chk(OFF_COUNT, 32'h3);
    rd_chk(OFF_BYTES, 32'hc);
    rd_chk(8'h18, 32'h0);
    // host selection, immediate
    wr(OFF_CTRL, 32'h2);
    rd_chk(OFF_CTRL, 32'h2);
    wr(OFF_SELECT, 32'h2);
    exp_load(3, 16'h2, 32'hd00, 32'ha20);
    wr(OFF_SELECT, 32'h4);
    no_load(8);
    far.ext_sel(8'h0);
    no_load(10);
    // host selection, coherent
    wr(OFF_CTRL, 32'h0);
    wr(OFF_SELECT, 32'h3);
    no_load(10);
    rd_chk(OFF_STATUS, 32'h20002);
    far.end_seg();
    exp_load(3, 16'h3, 32'h1720, 32'hc20);
    // external selection, immediate then coherent
    wr(OFF_CTRL, 32'h3);
    rd_chk(OFF_CTRL, 32'h3);
    far.ext_sel(8'h0);
    exp_load(10, 16'h1, 32'h0, 32'hd00);
    wr(OFF_SELECT, 32'h2);
    no_load(8);
    wr(OFF_CTRL, 32'h1);
    far.ext_sel(8'h2);
    no_load(10);
    far.end_seg();
    exp_load(3, 16'h3, 32'h1720, 32'hc20);
    // second channel keeps its own table
    wr(OFF_CTRL, 32'h10);
    rd_chk(OFF_COUNT, 32'h0);
    send_tbl('{32'h00c0});
    rd_chk(OFF_COUNT, 32'h1);
    wr(OFF_CTRL, 32'h0);
    rd_chk(OFF_COUNT, 32'h3);
    // reload replaces the table and numbers from one
    send_tbl('{32'h0100});
    rd_chk(OFF_COUNT, 32'h1);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_SELECT, 32'h1);
    exp_load(3, 16'h1, 32'h0, 32'h100);
    finish_test();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(8 * 5000);
    fail_count++;
    finish_test();
  end
endmodule
